//--- logic/sdram_row_addr_mux.sv
`timescale 1ns/1ps
`include "sdram_row_addr_mux_defines.svh"
module sdram_row_addr_mux #(
  parameter int INT_AW = 26,
  parameter int EXT_AW = 15
) (
  input wire logic i_clk_sys, // 250 MHz bus clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_field_we, // control byte write strobe
  input wire logic [7:0] i_field_wdata, // control byte write data
  input wire sdram_row_addr_mux_pkg::mux_cfg_t i_cfg, // mode and bus width
  input wire sdram_row_addr_mux_pkg::phase_req_t i_phase, // phase request
  input wire logic [INT_AW-1:0] i_addr, // internal byte address
  output logic [3:0] o_row_shift_select, // field readback
  output logic [EXT_AW-1:0] o_ext_addr, // external address pins
  output logic o_row_phase, // pins carry a row address
  output logic o_col_phase, // pins carry a column address
  output logic o_code_error // loaded code unusable here
);

  // the widest row shift must still leave the pins fed from real bits
  // refused at elaboration, so a bad size never reaches simulation
  if (EXT_AW + `ROW_SHIFT_MAX > INT_AW) begin : g_aw_check
    $error("sdram_row_addr_mux: INT_AW too small for EXT_AW");
  end
  if (EXT_AW < `ROW_START_PIN + 1) begin : g_pin_check
    $error("sdram_row_addr_mux: EXT_AW must reach pin A1");
  end

  logic [3:0] sel_q;
  logic [3:0] sel_d;
  logic [EXT_AW-1:0] ext_q;
  logic [EXT_AW-1:0] ext_d;
  logic err_q;
  logic err_d;
  logic row_q;
  logic col_q;
  sdram_row_addr_mux_pkg::phase_t phase_q;
  sdram_row_addr_mux_pkg::phase_t phase_d;

  wire code_a9_x16;
  wire code_a10;
  wire code_a9_x32;
  wire code_a10_256;
  wire code_a11;
  wire code_legal;
  wire width_bad;
  wire [3:0] sdram_start;
  wire [3:0] dram_start;
  wire [3:0] row_start;
  wire [3:0] row_shift;
  wire [EXT_AW-1:0] row_addr;
  wire [EXT_AW-1:0] col_addr;
  wire row_next;
  wire col_next;

  // field load; only bits 6..3 of the control byte belong to us
  assign sel_d = i_field_we ? i_field_wdata[`RSS_MSB:`RSS_LSB] : sel_q;

  // code decode for the synchronous interface
  assign code_a9_x16 = (sel_q == `RSS_CODE_A9_X16);
  assign code_a10 = (sel_q == `RSS_CODE_A10);
  assign code_a9_x32 = (sel_q == `RSS_CODE_A9_X32);
  assign code_a10_256 = (sel_q == `RSS_CODE_A10_256);
  assign code_a11 = (sel_q == `RSS_CODE_A11);
  assign code_legal = code_a9_x16 | code_a10 | code_a9_x32
                      | code_a10_256 | code_a11;

  // width mismatches are software faults; flagged, not corrected
  assign width_bad = (code_a11 & i_cfg.bus_32)
                     | (code_a9_x32 & ~i_cfg.bus_32);

  // start bit per code; prohibited codes fall back to A9 so pins stay sane
  assign sdram_start = code_a9_x16 ? `ROW_START_A9 :
                       code_a10 ? `ROW_START_A10 :
                       code_a9_x32 ? `ROW_START_A9 :
                       code_a10_256 ? `ROW_START_A10 :
                       code_a11 ? `ROW_START_A11 :
                       (`SHIFT_FALLBACK + 4'h1);

  // ordinary dram reads the field with its own shift table
  assign dram_start = `DRAM_SHIFT_BASE + {2'b00, sel_q[1:0]} + 4'h1;
  assign row_start = i_cfg.sdram_mode ? sdram_start : dram_start;

  // pin 0 takes the bit below the start, so pin A1 takes the start bit
  assign row_shift = row_start - 4'(`ROW_START_PIN);

  addr_shifter #(
    .IN_W(INT_AW),
    .OUT_W(EXT_AW)
  ) u_row_shift (
    .i_addr(i_addr),
    .i_shift(row_shift),
    .o_addr(row_addr)
  );

  // column phase uses the unshifted low address bits
  assign col_addr = i_addr[EXT_AW-1:0];

  // next phase; row takes priority if both are requested at once
  always_comb begin
    phase_d = phase_q;
    ext_d = ext_q;
    case (1'b1)
      i_phase.row: begin
        phase_d = sdram_row_addr_mux_pkg::PH_ROW;
        ext_d = row_addr;
      end
      i_phase.col: begin
        phase_d = sdram_row_addr_mux_pkg::PH_COL;
        ext_d = col_addr;
      end
      default: begin
        phase_d = sdram_row_addr_mux_pkg::PH_IDLE;
      end
    endcase
  end

  // phase flags get their own flops so the outputs carry no decode
  assign row_next = (phase_d == sdram_row_addr_mux_pkg::PH_ROW);
  assign col_next = (phase_d == sdram_row_addr_mux_pkg::PH_COL);

  // error flag only means something on the synchronous interface
  assign err_d = i_cfg.sdram_mode & (~code_legal | width_bad);

  // field register
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_q <= `RSS_RESET;
    end else begin
      sel_q <= sel_d;
    end
  end

  // pin and phase registers; pins hold their last value while idle
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase_q <= sdram_row_addr_mux_pkg::PH_IDLE;
      ext_q <= '0;
      err_q <= 1'b0;
      row_q <= 1'b0;
      col_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      ext_q <= ext_d;
      err_q <= err_d;
      row_q <= row_next;
      col_q <= col_next;
    end
  end

  assign o_row_shift_select = sel_q;
  assign o_ext_addr = ext_q;
  assign o_row_phase = row_q;
  assign o_col_phase = col_q;
  assign o_code_error = err_q;

  // checks on the field register, the error flag and the multiplexed pins
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  property p_field_load;
    i_field_we |=> o_row_shift_select
                   == $past(i_field_wdata[`RSS_MSB:`RSS_LSB])
      ##1 (o_row_shift_select == $past(o_row_shift_select)
           || $past(i_field_we));
  endproperty
  a_field_load: assert property (p_field_load)
    else $error("row shift field did not load or hold");

  property p_dram_shift;
    (i_phase.row && !i_cfg.sdram_mode && sel_q[1:0] == 2'b00)
      |=> o_row_phase && o_ext_addr[1] == $past(i_addr[9]);
  endproperty
  a_dram_shift: assert property (p_dram_shift)
    else $error("dram mode row shift wrong");

  property p_a9_x16;
    (i_phase.row && i_cfg.sdram_mode && sel_q == `RSS_CODE_A9_X16)
      |=> o_ext_addr[1] == $past(i_addr[9])
          && o_ext_addr[2] == $past(i_addr[10]);
  endproperty
  a_a9_x16: assert property (p_a9_x16)
    else $error("code 0100 did not put A9 on pin A1");

  property p_a10;
    (i_phase.row && i_cfg.sdram_mode && sel_q == `RSS_CODE_A10)
      |=> o_ext_addr[1] == $past(i_addr[10]) && o_row_phase;
  endproperty
  a_a10: assert property (p_a10)
    else $error("code 0101 did not put A10 on pin A1");

  property p_a9_x32;
    (i_phase.row && i_cfg.sdram_mode && sel_q == `RSS_CODE_A9_X32)
      |=> o_ext_addr[1] == $past(i_addr[9])
          && o_code_error == !$past(i_cfg.bus_32);
  endproperty
  a_a9_x32: assert property (p_a9_x32)
    else $error("code 0111 row address or width flag wrong");

  property p_a10_256;
    (i_phase.row && i_cfg.sdram_mode && sel_q == `RSS_CODE_A10_256)
      |=> o_ext_addr[1] == $past(i_addr[10])
          && o_ext_addr[0] == $past(i_addr[9]);
  endproperty
  a_a10_256: assert property (p_a10_256)
    else $error("code 1101 did not put A10 on pin A1");

  property p_a11;
    (i_phase.row && i_cfg.sdram_mode && sel_q == `RSS_CODE_A11)
      |=> o_ext_addr[1] == $past(i_addr[11])
          && o_code_error == $past(i_cfg.bus_32);
  endproperty
  a_a11: assert property (p_a11)
    else $error("code 1110 row address or width flag wrong");

  property p_col;
    (i_phase.col && !i_phase.row)
      |=> o_col_phase && o_ext_addr == $past(i_addr[EXT_AW-1:0]);
  endproperty
  a_col: assert property (p_col)
    else $error("column phase pins not unshifted");

endmodule : sdram_row_addr_mux

//--- logic/sdram_row_addr_mux_defines.svh
`ifndef SDRAM_ROW_ADDR_MUX_DEFINES_SVH
`define SDRAM_ROW_ADDR_MUX_DEFINES_SVH

// row-shift selection field inside the control byte
`define RSS_MSB 6
`define RSS_LSB 3
`define RSS_RESET 4'h0

// legal selection codes on the synchronous interface
`define RSS_CODE_A9_X16 4'h4
`define RSS_CODE_A10 4'h5
`define RSS_CODE_A9_X32 4'h7
`define RSS_CODE_A10_256 4'hD
`define RSS_CODE_A11 4'hE

// internal bit index that lands on external pin A1 in the row phase
`define ROW_START_A9 4'h9
`define ROW_START_A10 4'hA
`define ROW_START_A11 4'hB

// external pin that receives the row start bit
`define ROW_START_PIN 1

// largest shift in use (ordinary dram, field low bits 11): pins need the bits
`define ROW_SHIFT_MAX 11

// shift used for the ordinary dram interface: base plus low code bits
`define DRAM_SHIFT_BASE 4'h8

// shift fallback when a prohibited code is loaded
`define SHIFT_FALLBACK 4'h8

`endif

//--- logic/sdram_row_addr_mux_pkg.sv
package sdram_row_addr_mux_pkg;

  // one-hot phase of the multiplexed address pins
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_ROW = 3'b010,
    PH_COL = 3'b100
  } phase_t;

  // phase request from the bus cycle sequencer
  typedef struct packed {
    logic row;
    logic col;
  } phase_req_t;

  // configuration seen by the multiplexer
  typedef struct packed {
    logic sdram_mode;
    logic bus_32;
  } mux_cfg_t;

endpackage : sdram_row_addr_mux_pkg

//--- logic/addr_shifter.sv
`timescale 1ns/1ps
// right shift of the internal address, trimmed to the external pin width
module addr_shifter #(
  parameter int IN_W = 26,
  parameter int OUT_W = 15
) (
  input wire logic [IN_W-1:0] i_addr, // internal address
  input wire logic [3:0] i_shift, // pin 0 receives this bit index
  output logic [OUT_W-1:0] o_addr // shifted address
);

  // elaboration check: the shifter cannot invent bits above its input
  if (OUT_W > IN_W) begin : g_width_check
    $error("addr_shifter: output wider than input");
  end

  wire [IN_W-1:0] shifted;

  // barrel shift; upper bits fill with zero
  assign shifted = i_addr >> i_shift;
  assign o_addr = shifted[OUT_W-1:0];

endmodule : addr_shifter

//--- verification/sdram_model.sv
`timescale 1ns/1ps
// far-side memory part: keeps the last row and column it was handed
module sdram_model #(
  parameter int AW = 15
) (
  input wire logic i_clk_sys, // bus clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic [AW-1:0] i_addr, // address pins
  input wire logic i_row, // row strobe
  input wire logic i_col, // column strobe
  output logic [AW-1:0] o_row_q, // last row taken
  output logic [AW-1:0] o_col_q // last column taken
);
  // takes the pins on the edge that ends the phase, as a real part would
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_row_q <= '0;
      o_col_q <= '0;
    end else begin
      if (i_row) o_row_q <= i_addr;
      if (i_col) o_col_q <= i_addr;
    end
  end
endmodule : sdram_model

//--- verification/sdram_row_addr_mux_test.sv
`timescale 1ns/1ps
module sdram_row_addr_mux_test;
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_field_we = 1'b0;
  logic [7:0] i_field_wdata = 8'h00;
  sdram_row_addr_mux_pkg::mux_cfg_t i_cfg = '0;
  sdram_row_addr_mux_pkg::phase_req_t i_phase = '0;
  logic [25:0] i_addr = '0;
  logic [3:0] o_row_shift_select;
  logic [14:0] o_ext_addr, row_m, col_m;
  logic o_row_phase, o_col_phase, o_code_error;
  logic [7:0] seed = 8'h27;
  int n_fail = 0, total_checks = 0, cyc = 0;

  sdram_row_addr_mux dut_u (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_field_we(i_field_we), .i_field_wdata(i_field_wdata), .i_cfg(i_cfg),
    .i_phase(i_phase), .i_addr(i_addr),
    .o_row_shift_select(o_row_shift_select), .o_ext_addr(o_ext_addr),
    .o_row_phase(o_row_phase), .o_col_phase(o_col_phase),
    .o_code_error(o_code_error));
  sdram_model model_u (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_addr(o_ext_addr), .i_row(o_row_phase), .i_col(o_col_phase),
    .o_row_q(row_m), .o_col_q(col_m));

  // clock and a hang guard well above the few hundred cycles used
  always #2 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr

  // start bit lands on pin A1, so pin 0 carries start minus one
  function automatic logic [14:0] exp_row(logic [3:0] c, logic s,
                                          logic [25:0] a);
    int st;
    st = !s ? 9 + c[1:0] : (c == 4'h5 || c == 4'hD) ? 10 :
         (c == 4'hE) ? 11 : 9;
    return 15'(a >> (st - 1));
  endfunction : exp_row

  function automatic logic exp_err(logic [3:0] c, logic s, logic b);
    return s && !(c inside {4'h4, 4'h5, 4'hD} || (c == 4'h7 && b) ||
                  (c == 4'hE && !b));
  endfunction : exp_err

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // load a code, then one row and one column transfer
  task automatic run(input logic [3:0] c, input logic s, input logic b,
                     input logic ca);
    logic [25:0] a;
    repeat (4) begin
      seed = lfsr(seed);
      a = {a[17:0], seed};
    end
    @(negedge i_clk_sys);
    i_field_we = 1'b1;
    i_field_wdata = {seed[7], c, seed[2:0]};
    i_cfg = {s, b};
    @(negedge i_clk_sys);
    i_field_we = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    chk(o_row_shift_select, c);
    chk(o_code_error, exp_err(c, s, b));
    i_addr = a;
    i_phase.row = 1'b1;
    @(negedge i_clk_sys);
    chk(o_row_phase, 1'b1);
    if (ca) chk(o_ext_addr, exp_row(c, s, a));
    i_phase.row = 1'b0;
    i_phase.col = 1'b1;
    @(negedge i_clk_sys);
    chk(o_col_phase, 1'b1);
    chk(o_ext_addr, a[14:0]);
    i_phase.col = 1'b0;
    @(negedge i_clk_sys);
    if (ca) chk(row_m, exp_row(c, s, a));
    chk(col_m, a[14:0]);
  endtask : run

  task automatic summarize();
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // every code in sdram mode, then ordinary mode, random legal, width faults
  initial begin
    repeat (5) @(negedge i_clk_sys);
    i_reset_n = 1'b1;
    chk(o_row_shift_select, 4'h0);
    chk(o_ext_addr, 15'h0000);
    for (int i = 0; i < 16; i++)
      run(i[3:0], 1'b1, i == 7 ? 1'b1 : i == 14 ? 1'b0 : seed[0], 1'b1);
    repeat (6) run(seed[6:3], 1'b0, seed[1], 1'b1);
    // every low-bit pair of the ordinary dram table at least once
    for (int i = 0; i < 4; i++)
      run({2'b10, i[1:0]}, 1'b0, 1'b1, 1'b1);
    repeat (12) run(seed[0] ? 4'h5 : seed[1] ? 4'hD : 4'h4, 1'b1, seed[2],
                    1'b1);
    // reset in mid-run must clear a loaded field and the pins
    @(negedge i_clk_sys);
    i_reset_n = 1'b0;
    @(negedge i_clk_sys);
    chk(o_row_shift_select, 4'h0);
    chk(o_ext_addr, 15'h0000);
    chk(o_code_error, 1'b0);
    i_reset_n = 1'b1;
    run(4'hE, 1'b1, 1'b1, 1'b1);
    run(4'h7, 1'b1, 1'b0, 1'b1);
    summarize();
  end
endmodule : sdram_row_addr_mux_test
